// ### rdfoc_top.sv
// Purpose: I/Q decimating FIR with offset calibration and serial word output
// Assumes: all pins are asynchronous to CLK_I; SCLK_I is the serial link clock
// Notes:   tap weights are uniform; the link drops a pair if still shifting
// Summary of operation
// RQ1: 288-tap FIR stepped at half master rate
// RQ2: output twelve bit signed I and Q words
// RQ3: words valid after 288 fresh filter samples
// RQ4: clear every tap when leaving sleep
// RQ5: ignore modulator bits for 21 cycles after wake
// RQ6: subtract per channel offset from each result
// RQ7: offsets held at zero while calibrating
// RQ8: capture first result after calibration falls
// RQ9: controller holds calibration above 608 cycles
// RQ10: controller grounds inputs when calibration rises
// RQ11: calibration high may last any time
// RQ12: normal output resumes right after capture
// RQ13: offsets kept through sleep, changed by calibration
// RQ14: controller calibrates once after power up
// RQ15: format selects interleaved or split serial lines
// RQ16: rate select picks slow or fast words
// RQ17: ground select feeds modulators a zero signal
// RQ18: controller keeps ground low for external calibration
// RQ19: finish current pair before entering sleep
// RQ20: one pair per 24 or 48 cycles
// RQ21: offset subtraction saturates to twelve bits
`timescale 1ns/1ps
`default_nettype none
module rdfoc_top (
	input  wire logic CLK_I,                     // master clock
	input  wire logic RESETN_I,                  // async reset, active low
	input  wire logic CE_I,                      // clock enable, freezes state when low
	input  wire logic SCLK_I,                    // serial link clock
	input  wire logic MOD_I_BIT_I,               // I modulator bit stream
	input  wire logic MOD_Q_BIT_I,               // Q modulator bit stream
	input  wire logic CAL_STROBE_I,              // calibration strobe, active high
	input  wire logic RECEIVE_POWERDOWN_A_I,     // sleep pin a
	input  wire logic RECEIVE_POWERDOWN_B_I,     // sleep pin b
	input  wire logic MODULATOR_INPUT_GROUND_I,  // feed modulators zero signal
	input  wire logic FORMAT_SEL_I,              // low interleaved, high split
	input  wire logic RATE_SEL_I,                // low slow, high fast
	output logic [11:0] RX_I_WORD_O,             // corrected I word
	output logic [11:0] RX_Q_WORD_O,             // corrected Q word
	output logic      RX_WORD_STB_O,             // one cycle pulse per new pair
	output logic      RX_SETTLED_O,              // taps hold only fresh samples
	output logic      RX_ASLEEP_O,               // receive section sleeping
	output logic      SER_DATA_O,                // serial data line
	output logic      SER_IND_O,                 // I flag or Q data line
	output logic      SER_SYNC_O                 // first bit of each word
);
	// saturate a wide value to the word range
	function automatic rdfoc_pkg::rdfoc_word_t sat_word(input rdfoc_pkg::rdfoc_wide_t v);
		if (v > rdfoc_pkg::rdfoc_wide_t'(rdfoc_pkg::WORD_MAX))
			return rdfoc_pkg::WORD_MAX;
		else if (v < rdfoc_pkg::rdfoc_wide_t'(rdfoc_pkg::WORD_MIN))
			return rdfoc_pkg::WORD_MIN;
		else
			return v[11:0];
	endfunction
	// tap weight: stale tap adds nothing, fresh bit adds +1 or -1
	function automatic logic signed [9:0] tap_val(input logic b, input logic vld);
		if (!vld)
			return 10'sh000;
		else
			return b ? 10'sh001 : 10'sh3FF;
	endfunction
	// last count of the pair period
	function automatic logic [5:0] pair_last(input logic fast);
		return fast ? 6'(rdfoc_pkg::PAIR_CYC_FAST - 1) : 6'(rdfoc_pkg::PAIR_CYC_SLOW - 1);
	endfunction

	logic [6:0] sy1_r;                           // synchroniser first stage
	logic [6:0] sy2_r;                           // synchroniser second stage
	logic       modi_s, modq_s, cal_s, pda_s, pdb_s, gnd_s, rate_s;
	assign {modi_s, modq_s, cal_s, pda_s, pdb_s, gnd_s, rate_s} = sy2_r;

	// pin synchronisers, two stages each
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sy1_r <= 7'h00;
			sy2_r <= 7'h00;
		end else if (CE_I) begin
			sy1_r <= {MOD_I_BIT_I, MOD_Q_BIT_I, CAL_STROBE_I, RECEIVE_POWERDOWN_A_I,
			          RECEIVE_POWERDOWN_B_I, MODULATOR_INPUT_GROUND_I, RATE_SEL_I};
			sy2_r <= sy1_r;
		end
	end

	rdfoc_pkg::rdfoc_pwr_t state_r, state_nxt;   // power state
	logic [5:0]  dec_r, dec_nxt;                 // master cycles within pair
	logic        half_r, half_nxt;               // filter step phase
	logic        alt_r, alt_nxt;                 // zero signal bit pattern
	logic [4:0]  blank_r, blank_nxt;             // remaining garbage cycles
	logic [8:0]  fill_r, fill_nxt;               // fresh samples taken
	logic        settled_r, settled_nxt;         // all taps fresh
	logic        cald_r, cald_nxt;               // strobe one cycle back
	logic        arm_r, arm_nxt;                 // capture pending
	rdfoc_pkg::rdfoc_word_t ofs_i_r, ofs_i_nxt, ofs_q_r, ofs_q_nxt;   // offsets
	rdfoc_pkg::rdfoc_word_t word_i_r, word_i_nxt, word_q_r, word_q_nxt;
	logic        stb_r, stb_nxt;                 // new pair pulse
	logic        tog_r, tog_nxt;                 // pair toggle for the link
	logic [rdfoc_pkg::NUM_TAPS-1:0] tb_i_r, tb_i_nxt, tb_q_r, tb_q_nxt;  // tap bits
	logic [rdfoc_pkg::NUM_TAPS-1:0] tv_r, tv_nxt;                        // tap fresh flags
	logic signed [9:0] sum_i_r, sum_i_nxt, sum_q_r, sum_q_nxt;           // running sums
	logic        sleep_req, wake, filt_step, tick, new_vld, new_i, new_q;
	rdfoc_pkg::rdfoc_word_t raw_i, raw_q;        // filter results before offset

	assign sleep_req = pda_s & pdb_s;
	assign wake      = (state_r == rdfoc_pkg::RDFOC_SLEEP) && !sleep_req;
	// RQ1 half rate step
	assign filt_step = (state_r == rdfoc_pkg::RDFOC_RUN) && half_r;
	// RQ5 blank gate
	assign new_vld   = (blank_r == 5'h00);
	// RQ17 zero signal mux
	assign new_i     = gnd_s ? alt_r : modi_s;
	assign new_q     = gnd_s ? ~alt_r : modq_s;
	// RQ16 RQ20 rate picks pair boundary
	assign tick      = (state_r == rdfoc_pkg::RDFOC_RUN) && (dec_r >= pair_last(rate_s));
	// RQ2 twelve bit result
	assign raw_i     = sat_word(rdfoc_pkg::rdfoc_wide_t'(sum_i_r) * rdfoc_pkg::TAP_GAIN);
	assign raw_q     = sat_word(rdfoc_pkg::rdfoc_wide_t'(sum_q_r) * rdfoc_pkg::TAP_GAIN);

	// tap delay lines; uniform weights let a running sum replace 288 adders
	always_comb begin
		tb_i_nxt  = tb_i_r;
		tb_q_nxt  = tb_q_r;
		tv_nxt    = tv_r;
		sum_i_nxt = sum_i_r;
		sum_q_nxt = sum_q_r;
		if (wake) begin
			// RQ4 clear taps
			tb_i_nxt  = '0;
			tb_q_nxt  = '0;
			tv_nxt    = '0;
			sum_i_nxt = 10'sh000;
			sum_q_nxt = 10'sh000;
		end else if (filt_step) begin
			// RQ1 shift and accumulate
			tb_i_nxt  = {tb_i_r[rdfoc_pkg::NUM_TAPS-2:0], new_i};
			tb_q_nxt  = {tb_q_r[rdfoc_pkg::NUM_TAPS-2:0], new_q};
			tv_nxt    = {tv_r[rdfoc_pkg::NUM_TAPS-2:0], new_vld};
			sum_i_nxt = sum_i_r + tap_val(new_i, new_vld)
			          - tap_val(tb_i_r[rdfoc_pkg::NUM_TAPS-1], tv_r[rdfoc_pkg::NUM_TAPS-1]);
			sum_q_nxt = sum_q_r + tap_val(new_q, new_vld)
			          - tap_val(tb_q_r[rdfoc_pkg::NUM_TAPS-1], tv_r[rdfoc_pkg::NUM_TAPS-1]);
		end
	end

	// tap registers
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			tb_i_r  <= '0;
			tb_q_r  <= '0;
			tv_r    <= '0;
			sum_i_r <= 10'sh000;
			sum_q_r <= 10'sh000;
		end else if (CE_I) begin
			tb_i_r  <= tb_i_nxt;
			tb_q_r  <= tb_q_nxt;
			tv_r    <= tv_nxt;
			sum_i_r <= sum_i_nxt;
			sum_q_r <= sum_q_nxt;
		end
	end

	// sequencing, calibration and output words
	always_comb begin
		state_nxt   = state_r;
		dec_nxt     = dec_r;
		half_nxt    = half_r;
		alt_nxt     = alt_r;
		blank_nxt   = blank_r;
		fill_nxt    = fill_r;
		settled_nxt = (fill_r == 9'(rdfoc_pkg::NUM_TAPS));
		cald_nxt    = cal_s;
		arm_nxt     = arm_r;
		ofs_i_nxt   = ofs_i_r;
		ofs_q_nxt   = ofs_q_r;
		word_i_nxt  = word_i_r;
		word_q_nxt  = word_q_r;
		stb_nxt     = 1'b0;
		tog_nxt     = tog_r;
		if (cal_s) begin
			// RQ7 RQ11 offsets zero for as long as strobe stays high
			ofs_i_nxt = rdfoc_pkg::WORD_RST;
			ofs_q_nxt = rdfoc_pkg::WORD_RST;
			arm_nxt   = 1'b0;
		end else if (cald_r) begin
			// RQ8 falling edge arms capture
			arm_nxt = 1'b1;
		end
		case (state_r)
			rdfoc_pkg::RDFOC_RUN: begin
				half_nxt = ~half_r;
				if (filt_step)
					alt_nxt = ~alt_r;
				if (!new_vld)
					blank_nxt = blank_r - 5'h01;
				// RQ3 count fresh samples
				if (filt_step && new_vld && !settled_nxt)
					fill_nxt = fill_r + 9'h001;
				dec_nxt = tick ? 6'h00 : dec_r + 6'h01;
				if (tick) begin
					// RQ6 RQ21 saturating offset removal
					word_i_nxt = sat_word(rdfoc_pkg::rdfoc_wide_t'(raw_i)
					           - rdfoc_pkg::rdfoc_wide_t'(ofs_i_r));
					word_q_nxt = sat_word(rdfoc_pkg::rdfoc_wide_t'(raw_q)
					           - rdfoc_pkg::rdfoc_wide_t'(ofs_q_r));
					stb_nxt    = 1'b1;
					tog_nxt    = ~tog_r;
					// RQ8 RQ12 one capture, then normal output at once
					if (arm_r && !cal_s) begin
						ofs_i_nxt = raw_i;
						ofs_q_nxt = raw_q;
						arm_nxt   = 1'b0;
					end
					// RQ19 sleep only at pair boundary
					if (sleep_req)
						state_nxt = rdfoc_pkg::RDFOC_SLEEP;
				end
			end
			rdfoc_pkg::RDFOC_SLEEP: begin
				// RQ13 offsets kept; only calibration changes them
				if (!sleep_req) begin
					state_nxt = rdfoc_pkg::RDFOC_RUN;
					// RQ5 start blank window
					blank_nxt   = 5'(rdfoc_pkg::MOD_BLANK_CYC);
					fill_nxt    = 9'h000;
					settled_nxt = 1'b0;
					dec_nxt     = 6'h00;
					half_nxt    = 1'b0;
				end
			end
			default: state_nxt = rdfoc_pkg::RDFOC_RUN;
		endcase
	end

	// sequencing registers
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_r   <= rdfoc_pkg::RDFOC_RUN;
			dec_r     <= 6'h00;
			half_r    <= 1'b0;
			alt_r     <= 1'b0;
			blank_r   <= 5'(rdfoc_pkg::MOD_BLANK_CYC);
			fill_r    <= 9'h000;
			settled_r <= 1'b0;
			cald_r    <= 1'b0;
			arm_r     <= 1'b0;
			ofs_i_r   <= rdfoc_pkg::WORD_RST;
			ofs_q_r   <= rdfoc_pkg::WORD_RST;
			word_i_r  <= rdfoc_pkg::WORD_RST;
			word_q_r  <= rdfoc_pkg::WORD_RST;
			stb_r     <= 1'b0;
			tog_r     <= 1'b0;
		end else if (CE_I) begin
			state_r   <= state_nxt;
			dec_r     <= dec_nxt;
			half_r    <= half_nxt;
			alt_r     <= alt_nxt;
			blank_r   <= blank_nxt;
			fill_r    <= fill_nxt;
			settled_r <= settled_nxt;
			cald_r    <= cald_nxt;
			arm_r     <= arm_nxt;
			ofs_i_r   <= ofs_i_nxt;
			ofs_q_r   <= ofs_q_nxt;
			word_i_r  <= word_i_nxt;
			word_q_r  <= word_q_nxt;
			stb_r     <= stb_nxt;
			tog_r     <= tog_nxt;
		end
	end

	assign RX_I_WORD_O   = word_i_r;
	assign RX_Q_WORD_O   = word_q_r;
	assign RX_WORD_STB_O = stb_r;
	assign RX_SETTLED_O  = settled_r;
	assign RX_ASLEEP_O   = (state_r == rdfoc_pkg::RDFOC_SLEEP);

	// link side: words are stable 24 master cycles, so toggle qualified load is safe
	logic [2:0]  ltg_r;                          // pair toggle sync and edge stage
	logic [1:0]  lce_r, lfm_r;                   // enable and format synchronisers
	logic [23:0] sh_a_r, sh_a_nxt;               // data line shifter
	logic [11:0] sh_b_r, sh_b_nxt;               // Q line shifter, split format
	logic [4:0]  bits_r, bits_nxt;               // bits left in pair
	logic        lfmt_r, lfmt_nxt;               // format latched per pair
	logic        sd_r, sd_nxt, si_r, si_nxt, ss_r, ss_nxt;

	always_comb begin
		sh_a_nxt = sh_a_r;
		sh_b_nxt = sh_b_r;
		bits_nxt = bits_r;
		lfmt_nxt = lfmt_r;
		sd_nxt   = 1'b0;
		si_nxt   = 1'b0;
		ss_nxt   = 1'b0;
		if (bits_r != 5'h00) begin
			// RQ15 msb first, indicator or Q bit beside it
			sd_nxt   = sh_a_r[23];
			si_nxt   = lfmt_r ? sh_b_r[11] : (bits_r > 5'd12);
			ss_nxt   = (bits_r == 5'(rdfoc_pkg::SER_BITS)) || (bits_r == 5'd12);
			sh_a_nxt = {sh_a_r[22:0], 1'b0};
			sh_b_nxt = {sh_b_r[10:0], 1'b0};
			bits_nxt = bits_r - 5'h01;
		end else if (ltg_r[2] ^ ltg_r[1]) begin
			// RQ15 load pair in chosen layout
			lfmt_nxt = lfm_r[1];
			sh_a_nxt = lfm_r[1] ? {word_i_r, 12'h000} : {word_i_r, word_q_r};
			sh_b_nxt = word_q_r;
			bits_nxt = lfm_r[1] ? 5'd12 : 5'(rdfoc_pkg::SER_BITS);
		end
	end

	// link registers on the serial clock
	always_ff @(posedge SCLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			lce_r  <= 2'h0;
			ltg_r  <= 3'h0;
			lfm_r  <= 2'h0;
			sh_a_r <= 24'h000000;
			sh_b_r <= 12'h000;
			bits_r <= 5'h00;
			lfmt_r <= 1'b0;
			sd_r   <= 1'b0;
			si_r   <= 1'b0;
			ss_r   <= 1'b0;
		end else begin
			lce_r <= {lce_r[0], CE_I};
			if (lce_r[1]) begin
				ltg_r  <= {ltg_r[1:0], tog_r};
				lfm_r  <= {lfm_r[0], FORMAT_SEL_I};
				sh_a_r <= sh_a_nxt;
				sh_b_r <= sh_b_nxt;
				bits_r <= bits_nxt;
				lfmt_r <= lfmt_nxt;
				sd_r   <= sd_nxt;
				si_r   <= si_nxt;
				ss_r   <= ss_nxt;
			end
		end
	end

	assign SER_DATA_O = sd_r;
	assign SER_IND_O  = si_r;
	assign SER_SYNC_O = ss_r;

	chk_cal_zero: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ7
		(cal_s && CE_I) |=> (ofs_i_r == 12'h000) && (ofs_q_r == 12'h000))
		else $error("offset not zero during calibration");
	chk_ofs_capture: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ8
		(CE_I && tick && arm_r && !cal_s) |=> (ofs_i_r == $past(raw_i)) && !arm_r)
		else $error("offset capture missed");
	chk_ofs_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ13
		(!cal_s && !(tick && arm_r)) |=> $stable(ofs_i_r) && $stable(ofs_q_r))
		else $error("offset changed outside calibration");
	chk_wake_blank: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ5
		(CE_I && wake) |=> (blank_r == 5'(rdfoc_pkg::MOD_BLANK_CYC)) && !new_vld)
		else $error("blank window not started on wake");
	chk_wake_clear: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ4
		(CE_I && wake) |=> (tv_r == '0) && (sum_i_r == 10'sh000) && !settled_r)
		else $error("taps not cleared on wake");
	chk_word_sat: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ21
		(CE_I && tick) |=> stb_r && (word_i_r == sat_word(rdfoc_pkg::rdfoc_wide_t'($past(raw_i))
		- rdfoc_pkg::rdfoc_wide_t'($past(ofs_i_r)))))
		else $error("corrected word wrong");
	chk_half_step: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ1
		(CE_I && filt_step) |=> !filt_step)
		else $error("filter stepped at full rate");
	chk_pair_period: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ20
		(CE_I && tick && rate_s && $past(CE_I) && ($past(dec_r) < 6'd23))
		|-> (dec_r == 6'(rdfoc_pkg::PAIR_CYC_FAST - 1)))
		else $error("fast pair period wrong");
	chk_drain_pair: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RQ19
		(state_r == rdfoc_pkg::RDFOC_RUN && !tick) |=> (state_r == rdfoc_pkg::RDFOC_RUN))
		else $error("sleep entered mid pair");
endmodule
`default_nettype wire

// ### rdfoc_pkg.sv
// Purpose: shared constants and types for the receive decimating filter block
// Assumes: master clock CLK_I; filter steps on every second master cycle
// Notes:   all counts are in master clock cycles unless named otherwise
package rdfoc_pkg;
	localparam int NUM_TAPS      = 288;          // taps per channel filter
	localparam int WORD_W        = 12;           // output word width
	localparam int SUM_W         = 10;           // running tap sum, holds +-288
	localparam int WIDE_W        = 14;           // headroom for products and differences
	localparam int MOD_BLANK_CYC = 21;           // modulator garbage after wake
	localparam int PAIR_CYC_FAST = 24;           // master cycles per pair, fast rate
	localparam int PAIR_CYC_SLOW = 48;           // master cycles per pair, slow rate
	localparam int CNT_W         = 6;            // pair cycle counter width
	localparam int FILL_W        = 9;            // fresh sample counter width
	localparam int BLANK_W       = 5;            // blank counter width
	localparam int SER_BITS      = 24;           // serial bits per pair, interleaved
	localparam int SER_W         = 5;            // serial bit counter width
	typedef logic signed [WIDE_W-1:0] rdfoc_wide_t;   // sign extended working value
	typedef logic signed [WORD_W-1:0] rdfoc_word_t;   // output sample word
	localparam rdfoc_wide_t TAP_GAIN = 14'sh0007;     // scales tap sum to word range
	localparam rdfoc_word_t WORD_MAX = 12'sh7FF;      // positive saturation limit
	localparam rdfoc_word_t WORD_MIN = 12'sh800;      // negative saturation limit
	localparam rdfoc_word_t WORD_RST = 12'sh000;      // word and offset after reset
	typedef enum logic {RDFOC_RUN, RDFOC_SLEEP} rdfoc_pwr_t;  // receive power state
endpackage

// ### rdfoc_dsp_model.sv
// Purpose: receiving end of the serial sample link, rebuilds I and Q words
// Assumes: bits taken on the rising link clock; sync marks a word's first bit
// Notes:   idle lines are ignored; a frame counts once its last word lands
`timescale 1ns/1ps
`default_nettype none
module rdfoc_dsp_model (
	input  wire logic        sclk_i,     // link clock
	input  wire logic        data_i,     // serial data line
	input  wire logic        ind_i,      // I flag, or Q data when split
	input  wire logic        sync_i,     // first bit marker
	input  wire logic        split_i,    // high when I and Q use two lines
	output logic      [11:0] i_word_o,   // last I word received
	output logic      [11:0] q_word_o,   // last Q word received
	output logic      [11:0] frames_o,   // complete pairs received
	output logic      [11:0] ind_err_o   // flag changed inside a word
);
	logic [11:0] sh_d;   // data line shifter
	logic [11:0] sh_q;   // second line shifter
	logic [4:0]  cnt;    // bits of current word, zero when idle
	logic        is_i;   // flag level at word start
	initial begin
		frames_o  = 12'h000;
		ind_err_o = 12'h000;
		cnt       = 5'h00;
	end
	always @(posedge sclk_i) begin
		if (sync_i === 1'b1 || cnt != 5'h00) begin
			sh_d = {sh_d[10:0], data_i};
			sh_q = {sh_q[10:0], ind_i};
			if (sync_i === 1'b1) begin
				cnt  = 5'h01;
				is_i = ind_i;
			end else begin
				cnt = cnt + 5'h01;
				// a flag flip mid word would mislabel samples at the reader
				if (!split_i && ind_i !== is_i)
					ind_err_o = ind_err_o + 12'h001;
			end
			if (cnt == 5'h0C) begin
				cnt = 5'h00;
				if (split_i) begin
					i_word_o = sh_d;
					q_word_o = sh_q;
					frames_o = frames_o + 12'h001;
				end else if (is_i) begin
					i_word_o = sh_d;
				end else begin
					q_word_o = sh_d;
					frames_o = frames_o + 12'h001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### rdfoc_top_tb.sv
// Purpose: self-checking bench for the receive filter and offset block
// Assumes: bit 1 counts +1 and bit 0 counts -1; steady bits fill all taps
// Notes:   expected words come from tap count and gain, never the design
`timescale 1ns/1ps
`default_nettype none
module rdfoc_top_tb;
	localparam int FULL = rdfoc_pkg::NUM_TAPS * int'(rdfoc_pkg::TAP_GAIN); // full raw
	logic        clk, sclk, rst_n;            // clocks and reset
	logic        ce, mod_i, mod_q, cal;       // core inputs
	logic        pd_a, pd_b, gnd, fmt, rate;  // control pins
	logic [11:0] rx_i, rx_q;                  // corrected words
	logic        stb, settled, asleep;        // core status
	logic        sdata, sind, ssync;          // serial lines
	logic [11:0] m_i, m_q, m_frames, m_ierr;  // reader results
	logic [11:0] ierr0;                       // flag errors left from random phase
	int          fails, check_count, n, k;    // counters
	logic [31:0] seed, r;                     // random state
	rdfoc_top DUT (
		.CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .SCLK_I(sclk),
		.MOD_I_BIT_I(mod_i), .MOD_Q_BIT_I(mod_q), .CAL_STROBE_I(cal),
		.RECEIVE_POWERDOWN_A_I(pd_a), .RECEIVE_POWERDOWN_B_I(pd_b),
		.MODULATOR_INPUT_GROUND_I(gnd), .FORMAT_SEL_I(fmt), .RATE_SEL_I(rate),
		.RX_I_WORD_O(rx_i), .RX_Q_WORD_O(rx_q), .RX_WORD_STB_O(stb),
		.RX_SETTLED_O(settled), .RX_ASLEEP_O(asleep), .SER_DATA_O(sdata),
		.SER_IND_O(sind), .SER_SYNC_O(ssync)
	);
	rdfoc_dsp_model DSP (
		.sclk_i(sclk), .data_i(sdata), .ind_i(sind), .sync_i(ssync), .split_i(fmt),
		.i_word_o(m_i), .q_word_o(m_q), .frames_o(m_frames), .ind_err_o(m_ierr)
	);
	always #2 clk = ~clk;
	// link clock offset so its edges drift against the core clock
	initial begin
		sclk = 1'b0;
		#0.7;
		forever #3 sclk = ~sclk;
	end
	// expected word: difference clipped to the signed word range
	function automatic logic [11:0] sat_sub(input int a, input int b);
		int d;
		d = a - b;
		if (d > 2047) d = 2047;
		if (d < -2048) d = -2048;
		return d[11:0];
	endfunction
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// cycles until the next word strobe, bounded
	task automatic wait_stb(output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (stb !== 1'b1 && c < 400);
		if (c >= 400) chk(12'h000, 12'h001, "no word strobe");
	endtask
	// steady input long enough to refill every tap
	task automatic settle();
		int c;
		repeat (640) @(negedge clk);
		wait_stb(c);
		wait_stb(c);
	endtask
	task automatic ser_chk(input logic [11:0] ei, input logic [11:0] eq);
		logic [11:0] f0;
		int          c;
		f0 = m_frames;
		c  = 0;
		while (m_frames - f0 < 12'h003 && c < 400) begin
			@(negedge clk);
			c++;
		end
		if (c >= 400) chk(12'h000, 12'h001, "no serial frames");
		chk(m_i, ei, "serial i");
		chk(m_q, eq, "serial q");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang guard, well beyond the few thousand cycles expected
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		give_verdict();
	end
	initial begin
		clk = 1'b0; rst_n = 1'b0; ce = 1'b1; mod_i = 1'b0; mod_q = 1'b0; cal = 1'b0;
		pd_a = 1'b0; pd_b = 1'b0; gnd = 1'b0; fmt = 1'b0; rate = 1'b1;
		fails = 0; check_count = 0; seed = 32'h6789dd6c;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// noisy bits, enable gaps and modes before the steady checks
		repeat (150) begin
			@(posedge clk);
			r = $random(seed);
			mod_i <= r[0]; mod_q <= r[1]; ce <= r[2] | r[3]; fmt <= r[4]; rate <= r[5];
		end
		@(posedge clk);
		ce <= 1'b1; mod_i <= 1'b1; mod_q <= 1'b0; fmt <= 1'b0; rate <= 1'b1;
		settle();
		// random format flips confuse the reader; count only from here on
		ierr0 = m_ierr;
		chk(rx_i, sat_sub(FULL, 0), "i full scale");
		chk(rx_q, sat_sub(-FULL, 0), "q full scale");
		chk({11'h000, settled}, 12'h001, "settled");
		ser_chk(sat_sub(FULL, 0), sat_sub(-FULL, 0));
		chk(m_ierr, ierr0, "flag inside word");
		for (k = 0; k < 2; k++) begin
			@(posedge clk);
			rate <= k[0];
			wait_stb(n);
			wait_stb(n);
			wait_stb(n);
			chk(12'(n), k ? 12'h018 : 12'h030, "pair spacing");
		end
		// calibrate with steady, ungrounded inputs
		@(posedge clk);
		cal <= 1'b1;
		r = $random(seed);
		repeat (609 + int'(r[5:0]) - 100) @(posedge clk);
		wait_stb(n);
		chk(rx_i, sat_sub(FULL, 0), "i during cal");
		repeat (100) @(posedge clk);
		cal <= 1'b0;
		wait_stb(n);
		wait_stb(n);
		wait_stb(n);
		chk(rx_i, 12'h000, "i after cal");
		chk(rx_q, 12'h000, "q after cal");
		@(posedge clk);
		mod_i <= 1'b0; mod_q <= 1'b1; fmt <= 1'b1;
		settle();
		chk(rx_i, sat_sub(-FULL, FULL), "i clipped");
		chk(rx_q, sat_sub(FULL, -FULL), "q clipped");
		ser_chk(sat_sub(-FULL, FULL), sat_sub(FULL, -FULL));
		@(posedge clk);
		pd_a <= 1'b1; pd_b <= 1'b1;
		n = 0;
		while (asleep !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk({11'h000, asleep}, 12'h001, "asleep");
		chk({11'h000, stb}, 12'h001, "last pair");
		k = 0;
		repeat (200) begin
			@(negedge clk);
			if (stb !== 1'b0) k++;
		end
		chk(12'(k), 12'h000, "strobe asleep");
		@(posedge clk);
		pd_a <= 1'b0;
		n = 0;
		while (asleep !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk({11'h000, settled}, 12'h000, "taps cleared");
		n = 0;
		while (settled !== 1'b1 && n < 700) begin
			@(negedge clk);
			n++;
		end
		chk({11'h000, n >= 590 && n <= 640}, 12'h001, "refill time");
		@(posedge clk);
		pd_b <= 1'b0;
		wait_stb(n);
		wait_stb(n);
		chk(rx_i, sat_sub(-FULL, FULL), "i offset kept");
		chk(rx_q, sat_sub(FULL, -FULL), "q offset kept");
		@(posedge clk);
		gnd <= 1'b1;
		settle();
		chk(rx_i, sat_sub(0, FULL), "i grounded");
		chk(rx_q, sat_sub(0, -FULL), "q grounded");
		// recalibrate while offsets are nonzero, so zeroing shows
		@(posedge clk);
		cal <= 1'b1;
		wait_stb(n);
		wait_stb(n);
		chk(rx_i, 12'h000, "i zero in cal");
		chk(rx_q, 12'h000, "q zero in cal");
		repeat (620) @(posedge clk);
		cal <= 1'b0;
		wait_stb(n);
		wait_stb(n);
		wait_stb(n);
		chk(rx_i, 12'h000, "i recal");
		chk(rx_q, 12'h000, "q recal");
		give_verdict();
	end
endmodule
`default_nettype wire
